/* File: hdl/qbc_ctrl.v */
// Microprogrammed controller joining a peripheral to an asynchronous word bus.
// Assumes one clock, a synchronous reset, an APB master and open-drain bus
// buffers outside that resolve each line from its enable.
//
// What this block does
// - Reset at address 63, then idle loop
// - Idle checks slave, then DMA, then interrupt
// - Slave request samples WTBT to choose direction
// - Slave read: RPLY and data while DIN
// - Slave write: RPLY and capture while DOUT
// - Interrupt: wait DIN low, IRQ until acknowledge
// - Grant: RPLY plus vector, then complete pulse
// - 32-bit microword: upper sequencing, lower aux test and controls
// - All test inputs registered on our clock
// - Three-bit test select picks branch condition
// - Auxiliary select adds six more conditions
// - Polarity bit inverts the selected condition
// - Six-bit field: target, mask or count
// - Error bit flags an abandoned handshake
// - Twelve control bits in fixed order
// - Complete flag with all bus lines released
// - Single-word DMA and one interrupt level
// - DMA: grant low, DMR, wait idle, SACK
// - Master read with timeout, capture, complete
// - Master write with timeout, hold, complete
//
// The register addresses and the APB register port are this design's own decisions.
`include "qbc_consts.vh"
`default_nettype none
module qbc_ctrl #(
    parameter DW = 16
) (
    input  wire          clk_sys,
    input  wire          rst,
    // APB slave.
    input  wire          psel,
    input  wire          penable,
    input  wire          pwrite,
    input  wire [7:0]    paddr,
    input  wire [31:0]   pwdata,
    output reg  [31:0]   prdata,
    output reg           pready,
    output reg           pslverr,
    // Bus lines, asserted high here; buffers invert to the wire levels.
    input  wire          sync_in,
    output wire          sync_out,
    output wire          sync_oe,
    input  wire          din_in,
    output wire          din_out,
    output wire          din_oe,
    input  wire          dout_in,
    output wire          dout_out,
    output wire          dout_oe,
    input  wire          wtbt_in,
    output wire          wtbt_out,
    output wire          wtbt_oe,
    input  wire          rply_in,
    output wire          rply_out,
    output wire          rply_oe,
    output wire          irq_out,
    output wire          dmr_out,
    output wire          sack_out,
    input  wire          iak_in,
    input  wire          dmg_in,
    input  wire [DW-1:0] bus_da_in,
    output reg  [DW-1:0] bus_da_out,
    output reg           bus_da_oe,
    // Peripheral side.
    input  wire          xfer_req,
    input  wire          dma_req,
    input  wire          int_req,
    input  wire          wr_req,
    input  wire [DW-1:0] per_rdata,
    input  wire [DW-1:0] dma_addr,
    input  wire [DW-1:0] dma_wdata,
    output reg  [DW-1:0] per_wdata,
    output reg           per_capture,
    output wire          per_complete,
    output wire          per_error
);

    reg  [31:0]   pipe;       // Pipeline microword now executing.
    reg  [5:0]    pc;         // Address of the word in the pipeline.
    reg  [5:0]    ret_pc;     // Return address; one call level suffices.
    reg  [5:0]    cnt;        // Timeout down-counter.
    reg           eq;         // Result of the last compare.
    reg  [9:0]    syn_a;      // Ten-bit input synchroniser.
    reg           syn_b;      // Extra flip-flop for the eleventh input.
    reg           ctrl_run;   // Software run enable.
    reg  [DW-1:0] vector;     // Interrupt vector given to the host.
    reg  [5:0]    next_pc;
    reg  [5:0]    next_ret;
    reg  [5:0]    next_cnt;
    reg           next_eq;
    reg           tsel;       // Selected raw test condition.
    reg           asel;       // Selected auxiliary condition.
    wire [4:0]    op;
    wire [2:0]    tst;
    wire [2:0]    aux;
    wire [5:0]    dat;
    wire          cond;
    wire [31:0]   nw;         // Word that the next edge will load.
    wire          apb_acc;

    // Packs one microword: enable, opcode, polarity, test, data, outputs.
    function [31:0] uw;
        input [4:0]  f_op;
        input        f_pol;
        input [2:0]  f_tst;
        input [5:0]  f_dat;
        input [2:0]  f_aux;
        input [15:0] f_out;
        begin
            uw = {1'b1, f_op, f_pol, f_tst, f_dat, f_out[15], f_aux, f_out[11:0]};
        end
    endfunction

    // Control store; unused words fall back to the reset word.
    function [31:0] rom;
        input [5:0] a;
        begin
            case (a)
                6'd0:  rom = uw(`QBC_OP_CALL, 1'b0, `QBC_T_AUX, 6'd10, `QBC_A_XREQ, `QBC_O_OFF);
                6'd1:  rom = uw(`QBC_OP_CALL, 1'b0, `QBC_T_AUX, 6'd17, `QBC_A_DREQ, `QBC_O_OFF);
                6'd2:  rom = uw(`QBC_OP_GOTO, 1'b1, `QBC_T_AUX, 6'd0, `QBC_A_IREQ, `QBC_O_OFF);
                6'd3:  rom = uw(`QBC_OP_GOTO, 1'b0, `QBC_T_DIN, 6'd3, 3'h0, `QBC_O_OFF);
                6'd4:  rom = uw(`QBC_OP_GOTO, 1'b1, `QBC_T_DIN, 6'd4, 3'h0, `QBC_O_IRQ);
                6'd5:  rom = uw(`QBC_OP_GOTO, 1'b1, `QBC_T_IAK, 6'd5, 3'h0, `QBC_O_IRQ);
                6'd6:  rom = uw(`QBC_OP_GOTO, 1'b0, `QBC_T_DIN, 6'd6, 3'h0,
                                `QBC_O_RPLY & `QBC_O_DATAOUT);
                6'd7:  rom = uw(`QBC_OP_GOTO, 1'b0, `QBC_T_IAK, 6'd7, 3'h0,
                                `QBC_O_RPLY & `QBC_O_DATAOUT);
                6'd8:  rom = uw(`QBC_OP_GOTO, 1'b0, `QBC_T_PASS, 6'd0, 3'h0, `QBC_O_COMPLT);
                6'd10: rom = uw(`QBC_OP_GOTO, 1'b0, `QBC_T_AUX, 6'd14, `QBC_A_WTBT, `QBC_O_OFF);
                6'd11: rom = uw(`QBC_OP_GOTO, 1'b1, `QBC_T_DIN, 6'd11, 3'h0, `QBC_O_OFF);
                6'd12: rom = uw(`QBC_OP_GOTO, 1'b0, `QBC_T_DIN, 6'd12, 3'h0,
                                `QBC_O_RPLY & `QBC_O_DATAOUT);
                6'd13: rom = uw(`QBC_OP_RET, 1'b0, `QBC_T_PASS, 6'd0, 3'h0, `QBC_O_OFF);
                6'd14: rom = uw(`QBC_OP_GOTO, 1'b1, `QBC_T_AUX, 6'd14, `QBC_A_DOUT, `QBC_O_OFF);
                6'd15: rom = uw(`QBC_OP_GOTO, 1'b0, `QBC_T_AUX, 6'd15, `QBC_A_DOUT,
                                `QBC_O_RPLY | `QBC_O_DATAIN);
                6'd16: rom = uw(`QBC_OP_RET, 1'b0, `QBC_T_PASS, 6'd0, 3'h0, `QBC_O_OFF);
                // one word per grant, no block
                // request, grant, wait for an idle bus
                6'd17: rom = uw(`QBC_OP_GOTO, 1'b0, `QBC_T_DMG, 6'd17, 3'h0, `QBC_O_OFF);
                6'd18: rom = uw(`QBC_OP_GOTO, 1'b1, `QBC_T_DMG, 6'd18, 3'h0, `QBC_O_DMR);
                6'd19: rom = uw(`QBC_OP_CMP, 1'b0, `QBC_T_PASS, `QBC_M_SYNCRPLY, 3'h0,
                                `QBC_O_DMR);
                6'd20: rom = uw(`QBC_OP_GOTO, 1'b1, `QBC_T_EQ, 6'd19, 3'h0, `QBC_O_DMR);
                6'd21: rom = uw(`QBC_OP_GOTO, 1'b0, `QBC_T_AUX, 6'd34, `QBC_A_WREQ, `QBC_O_SACK);
                6'd22,
                6'd23: rom = uw(`QBC_OP_CONT, 1'b0, `QBC_T_PASS, 6'd0, 3'h0,
                                `QBC_O_SACK & `QBC_O_ADDROUT);
                6'd24: rom = uw(`QBC_OP_CONT, 1'b0, `QBC_T_PASS, 6'd0, 3'h0,
                                (`QBC_O_SACK | `QBC_O_SYNC) & `QBC_O_ADDROUT);
                6'd25: rom = uw(`QBC_OP_LOAD, 1'b0, `QBC_T_PASS, `QBC_TMO_LOAD, 3'h0,
                                (`QBC_O_SACK | `QBC_O_SYNC) & `QBC_O_ADDROUT);
                6'd26: rom = uw(`QBC_OP_LOOP, 1'b0, `QBC_T_RPLY, 6'd28, 3'h0,
                                `QBC_O_SACK | `QBC_O_SYNC | `QBC_O_DIN);
                6'd27: rom = uw(`QBC_OP_RET, 1'b0, `QBC_T_PASS, 6'd0, 3'h0,
                                `QBC_O_SACK | `QBC_O_SYNC | `QBC_O_ERROR);
                6'd28,
                6'd29: rom = uw(`QBC_OP_CONT, 1'b0, `QBC_T_PASS, 6'd0, 3'h0,
                                `QBC_O_SACK | `QBC_O_SYNC | `QBC_O_DIN | `QBC_O_DATAIN);
                6'd30: rom = uw(`QBC_OP_GOTO, 1'b0, `QBC_T_RPLY, 6'd30, 3'h0,
                                `QBC_O_SACK | `QBC_O_SYNC);
                6'd31: rom = uw(`QBC_OP_RET, 1'b0, `QBC_T_PASS, 6'd0, 3'h0, `QBC_O_COMPLT);
                6'd34,
                6'd35: rom = uw(`QBC_OP_CONT, 1'b0, `QBC_T_PASS, 6'd0, 3'h0,
                                (`QBC_O_SACK | `QBC_O_WTBT) & `QBC_O_ADDROUT);
                6'd36: rom = uw(`QBC_OP_CONT, 1'b0, `QBC_T_PASS, 6'd0, 3'h0,
                                (`QBC_O_SACK | `QBC_O_WTBT | `QBC_O_SYNC) & `QBC_O_ADDROUT);
                6'd37: rom = uw(`QBC_OP_LOAD, 1'b0, `QBC_T_PASS, `QBC_TMO_LOAD, 3'h0,
                                (`QBC_O_SACK | `QBC_O_WTBT | `QBC_O_SYNC) & `QBC_O_ADDROUT);
                6'd38: rom = uw(`QBC_OP_LOOP, 1'b0, `QBC_T_RPLY, 6'd40, 3'h0,
                                (`QBC_O_SACK | `QBC_O_SYNC | `QBC_O_DOUT) & `QBC_O_DATAOUT);
                6'd39: rom = uw(`QBC_OP_RET, 1'b0, `QBC_T_PASS, 6'd0, 3'h0,
                                `QBC_O_SACK | `QBC_O_SYNC | `QBC_O_ERROR);
                6'd40,
                6'd41: rom = uw(`QBC_OP_CONT, 1'b0, `QBC_T_PASS, 6'd0, 3'h0,
                                (`QBC_O_SACK | `QBC_O_SYNC | `QBC_O_DOUT) & `QBC_O_DATAOUT);
                6'd42,
                6'd43: rom = uw(`QBC_OP_CONT, 1'b0, `QBC_T_PASS, 6'd0, 3'h0,
                                (`QBC_O_SACK | `QBC_O_SYNC) & `QBC_O_DATAOUT);
                6'd44: rom = uw(`QBC_OP_GOTO, 1'b0, `QBC_T_RPLY, 6'd44, 3'h0,
                                `QBC_O_SACK | `QBC_O_SYNC);
                6'd45: rom = uw(`QBC_OP_RET, 1'b0, `QBC_T_PASS, 6'd0, 3'h0, `QBC_O_COMPLT);
                default: rom = `QBC_WORD_RESET;
            endcase
        end
    endfunction

    // upper half and the aux field sequence, rest of lower half drives pins
    assign op  = pipe[`QBC_F_OP_HI:`QBC_F_OP_LO];
    assign tst = pipe[`QBC_F_TST_HI:`QBC_F_TST_LO];
    assign dat = pipe[`QBC_F_DAT_HI:`QBC_F_DAT_LO];
    assign aux = pipe[`QBC_F_AUX_HI:`QBC_F_AUX_LO];

    // auxiliary condition; spare codes read as false.
    always @*
    begin
        case (aux)
            `QBC_A_XREQ: asel = syn_a[5];
            `QBC_A_DREQ: asel = syn_a[6];
            `QBC_A_IREQ: asel = syn_a[7];
            `QBC_A_WREQ: asel = syn_a[8];
            `QBC_A_DOUT: asel = syn_a[9];
            `QBC_A_WTBT: asel = syn_b;
            default:     asel = 1'b0;
        endcase
    end

    // main test select, all from registered inputs.
    always @*
    begin
        case (tst)
            `QBC_T_SYNC: tsel = syn_a[0];
            `QBC_T_RPLY: tsel = syn_a[1];
            `QBC_T_DIN:  tsel = syn_a[2];
            `QBC_T_DMG:  tsel = syn_a[3];
            `QBC_T_IAK:  tsel = syn_a[4];
            `QBC_T_AUX:  tsel = asel;
            `QBC_T_PASS: tsel = 1'b1;
            default:     tsel = eq;
        endcase
    end

    assign cond = tsel ^ pipe[`QBC_F_POL];

    // Next-address logic; the counter and the compare share the data field.
    always @*
    begin
        next_pc  = pc + 6'h01;
        next_ret = ret_pc;
        next_cnt = cnt;
        next_eq  = eq;
        case (op)
            `QBC_OP_GOTO:
            begin
                if (cond)
                    next_pc = dat;
            end
            `QBC_OP_CALL:
            begin
                if (cond)
                begin
                    next_ret = pc + 6'h01;
                    next_pc  = dat;
                end
            end
            `QBC_OP_RET:
                next_pc = ret_pc;
            `QBC_OP_LOAD:
                next_cnt = dat;
            `QBC_OP_CMP:
                next_eq = ((syn_a[5:0] & dat) == 6'h00);
            `QBC_OP_LOOP:
            begin
                // A reply wins; otherwise wait here until the count runs out.
                if (cond)
                    next_pc = dat;
                else if (cnt != 6'h00)
                begin
                    next_cnt = cnt - 6'h01;
                    next_pc  = pc;
                end
            end
            default:
                next_pc = pc + 6'h01;
        endcase
        // Software stop parks the sequencer on the reset word.
        if (!ctrl_run)
            next_pc = `QBC_ADDR_RESET;
    end

    assign nw = rom(next_pc);

    // Sequencer registers and the pipeline word.
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            // start at 63, idle loop follows
            pc     <= `QBC_ADDR_RESET;
            pipe   <= `QBC_WORD_RESET;
            ret_pc <= 6'h00;
            cnt    <= 6'h00;
            eq     <= 1'b0;
        end
        else
        begin
            pc     <= next_pc;
            pipe   <= nw;
            ret_pc <= next_ret;
            cnt    <= next_cnt;
            eq     <= next_eq;
        end
    end

    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            syn_a <= 10'h000;
            syn_b <= 1'b0;
        end
        else
        begin
            syn_a <= {dout_in, wr_req, int_req, dma_req, xfer_req,
                      iak_in, dmg_in, din_in, rply_in, sync_in};
            syn_b <= wtbt_in;
        end
    end

    // Bus data drivers are registered from the word about to execute.
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            bus_da_out <= {DW{1'b0}};
            bus_da_oe  <= 1'b0;
        end
        else
        begin
            bus_da_oe <= nw[`QBC_F_OE] & ~(nw[`QBC_B_AGATE] & nw[`QBC_B_DGATE]);
            if (!nw[`QBC_B_AGATE])
                bus_da_out <= dma_addr;
            else if (nw[`QBC_B_SACK])
                bus_da_out <= dma_wdata;
            else if (syn_a[4])
                bus_da_out <= vector;
            else
                bus_da_out <= per_rdata;
        end
    end

    // Capture strobe lags the word by one edge so data and strobe align.
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            per_wdata   <= {DW{1'b0}};
            per_capture <= 1'b0;
        end
        else
        begin
            per_capture <= pipe[`QBC_B_DATAIN];
            if (pipe[`QBC_B_DATAIN])
                per_wdata <= bus_da_in;
        end
    end

    // control bits straight from the pipeline
    assign sync_out     = pipe[`QBC_B_SYNC];
    assign sync_oe      = pipe[`QBC_B_SYNC];
    assign din_out      = pipe[`QBC_B_DIN];
    assign din_oe       = pipe[`QBC_B_DIN];
    assign dout_out     = pipe[`QBC_B_DOUT];
    assign dout_oe      = pipe[`QBC_B_DOUT];
    assign wtbt_out     = pipe[`QBC_B_WTBT];
    assign wtbt_oe      = pipe[`QBC_B_WTBT];
    assign rply_out     = pipe[`QBC_B_RPLY];
    assign rply_oe      = pipe[`QBC_B_RPLY];
    assign irq_out      = pipe[`QBC_B_IRQ];
    assign dmr_out      = pipe[`QBC_B_DMR];
    assign sack_out     = pipe[`QBC_B_SACK];
    // complete flag from its own word
    assign per_complete = pipe[`QBC_B_COMPLT];
    assign per_error    = pipe[`QBC_F_ERR];

    // APB slave: one wait state, then pready with registered data.
    assign apb_acc = psel & penable & ~pready;

    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            pready   <= 1'b0;
            pslverr  <= 1'b0;
            prdata   <= 32'h0000_0000;
            ctrl_run <= `QBC_CTRL_RST;
            vector   <= `QBC_VEC_RST;
        end
        else
        begin
            pready  <= apb_acc;
            pslverr <= 1'b0;
            if (apb_acc)
            begin
                prdata <= 32'h0000_0000;
                case (paddr)
                    `QBC_REG_CTRL:
                    begin
                        if (pwrite)
                            ctrl_run <= pwdata[0];
                        prdata <= {31'h0000_0000, ctrl_run};
                    end
                    `QBC_REG_VECTOR:
                    begin
                        if (pwrite)
                            vector <= pwdata[DW-1:0];
                        prdata <= {{(32-DW){1'b0}}, vector};
                    end
                    `QBC_REG_STATUS:
                        prdata <= {19'h0_0000, eq, cnt, pc};
                    `QBC_REG_DATA:
                        prdata <= {{(32-DW){1'b0}}, per_wdata};
                    default:
                        pslverr <= 1'b1;
                endcase
            end
        end
    end

endmodule // qbc_ctrl
`default_nettype wire

/* File: pkg/qbc_consts.vh */
// Constants for the asynchronous bus slave, interrupt and DMA sequencer.
// Assumes it is included by bare name from the design file only.
`ifndef QBC_CONSTS_VH
`define QBC_CONSTS_VH
// Sequencer reset address and the word stored there (goto 0, bus idle).
`define QBC_ADDR_RESET 6'h3F
`define QBC_WORD_RESET 32'hE5800300
// Microword field positions.
`define QBC_F_OE       31
`define QBC_F_OP_HI    30
`define QBC_F_OP_LO    26
`define QBC_F_POL      25
`define QBC_F_TST_HI   24
`define QBC_F_TST_LO   22
`define QBC_F_DAT_HI   21
`define QBC_F_DAT_LO   16
`define QBC_F_ERR      15
`define QBC_F_AUX_HI   14
`define QBC_F_AUX_LO   12
`define QBC_B_COMPLT   11
`define QBC_B_DATAIN   10
`define QBC_B_DGATE    9
`define QBC_B_AGATE    8
`define QBC_B_RPLY     7
`define QBC_B_IRQ      6
`define QBC_B_DMR      5
`define QBC_B_SACK     4
`define QBC_B_DOUT     3
`define QBC_B_DIN      2
`define QBC_B_SYNC     1
`define QBC_B_WTBT     0
// Next-address opcodes.
`define QBC_OP_RET     5'h02
`define QBC_OP_LOAD    5'h04
`define QBC_OP_LOOP    5'h08
`define QBC_OP_CONT    5'h0D
`define QBC_OP_CMP     5'h10
`define QBC_OP_GOTO    5'h19
`define QBC_OP_CALL    5'h1C
// Test select codes.
`define QBC_T_SYNC     3'h0
`define QBC_T_RPLY     3'h1
`define QBC_T_DIN      3'h2
`define QBC_T_DMG      3'h3
`define QBC_T_IAK      3'h4
`define QBC_T_AUX      3'h5
`define QBC_T_PASS     3'h6
`define QBC_T_EQ       3'h7
// Auxiliary test codes.
`define QBC_A_XREQ     3'h0
`define QBC_A_DREQ     3'h1
`define QBC_A_IREQ     3'h2
`define QBC_A_WREQ     3'h3
`define QBC_A_DOUT     3'h4
`define QBC_A_WTBT     3'h5
// Control output patterns; gates on bits 9 and 8 are active low.
`define QBC_O_OFF      16'h0300
`define QBC_O_ERROR    16'h8300
`define QBC_O_COMPLT   16'h0B00
`define QBC_O_DATAIN   16'h0700
`define QBC_O_DATAOUT  16'hFDFF
`define QBC_O_ADDROUT  16'hFEFF
`define QBC_O_RPLY     16'h0380
`define QBC_O_IRQ      16'h0340
`define QBC_O_DMR      16'h0320
`define QBC_O_SACK     16'h0310
`define QBC_O_DOUT     16'h0308
`define QBC_O_DIN      16'h0304
`define QBC_O_SYNC     16'h0302
`define QBC_O_WTBT     16'h0301
// Handshake masks and counts.
`define QBC_M_SYNCRPLY 6'h03
`define QBC_TMO_LOAD   6'h2B
// APB register byte offsets and reset values.
`define QBC_REG_CTRL   8'h00
`define QBC_REG_VECTOR 8'h04
`define QBC_REG_STATUS 8'h08
`define QBC_REG_DATA   8'h0C
`define QBC_CTRL_RST   1'b1
`define QBC_VEC_RST    16'h0000
`endif

/* File: dv/qbc_asserts.sv */
// Port checker for the bus sequencer.
// Assumes it is bound to qbc_ctrl and sees only its ports.
`default_nettype none
module qbc_asserts (
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic [7:0] paddr,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       sync_out,
    input wire logic       din_out,
    input wire logic       dout_out,
    input wire logic       rply_out,
    input wire logic       irq_out,
    input wire logic       dmr_out,
    input wire logic       sack_out,
    input wire logic       bus_da_oe,
    input wire logic       per_complete,
    input wire logic       per_error
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // First access-phase edge of an APB transfer.
    wire logic take = psel && penable && !pready;
    // Any bus control line that the sequencer drives, except WTBT.
    wire logic busy = rply_out | sync_out | sack_out | din_out | dout_out | irq_out | dmr_out;
    a_reset_off: assert property ($fell(rst) |-> !busy && !bus_da_oe)
        else $error("bus driven after reset");
    a_apb_answer: assert property (take |=> pready ##1 !pready)
        else $error("apb answer late or long");
    a_unmapped_err: assert property (take && paddr > 8'h0C |=> pslverr)
        else $error("unmapped access without error");
    a_sack_after_dmr: assert property ($rose(sack_out) |-> $past(dmr_out))
        else $error("sack without prior request");
    a_dmr_until_sack: assert property ($fell(dmr_out) |-> sack_out)
        else $error("request dropped before mastership");
    a_reply_slave: assert property (rply_out |-> !sack_out && !dmr_out && !irq_out)
        else $error("reply while master or requesting");
    a_irq_vector: assert property ($fell(irq_out) |-> rply_out && bus_da_oe)
        else $error("interrupt ended without vector");
    a_complete_off: assert property (per_complete |-> !busy ##1 !per_complete)
        else $error("complete with bus driven or long");
    a_error_abort: assert property (per_error |-> sack_out && !din_out ##1 !sack_out)
        else $error("timeout exit malformed");
    c_irq: cover property ($rose(irq_out));
    c_sack: cover property ($rose(sack_out));
    c_err: cover property (per_error);
endmodule // qbc_asserts
bind qbc_ctrl qbc_asserts u_chk (.*);
`default_nettype wire

/* File: dv/qbc_host.sv */
// Bus host, arbiter and memory model facing the sequencer.
// Assumes asserted-high levels; each control line is the OR of all drivers.
`default_nettype none
module qbc_host (
    input  wire logic        clk_sys,
    input  wire logic        sync_out,
    input  wire logic        din_out,
    input  wire logic        dout_out,
    input  wire logic        wtbt_out,
    input  wire logic        rply_out,
    input  wire logic        irq_out,
    input  wire logic        dmr_out,
    input  wire logic        sack_out,
    input  wire logic [15:0] bus_da_out,
    input  wire logic        bus_da_oe,
    output wire logic        sync_in,
    output wire logic        din_in,
    output wire logic        dout_in,
    output wire logic        wtbt_in,
    output wire logic        rply_in,
    output var  logic        iak_in,
    output var  logic        dmg_in,
    output wire logic [15:0] bus_da_in,
    output var  logic        xfer_req
);
    timeunit 1ns;
    timeprecision 1ns;
    logic h_sync = 0, h_din = 0, h_dout = 0, h_wtbt = 0, h_oe = 0, m_rply = 0, mem_en = 0;
    logic [15:0] h_da = 0, nz = 0, mem_data = 0;
    int mem_lat = 0, cnt = 0;
    assign sync_in = h_sync | sync_out;
    assign din_in = h_din | din_out;
    assign dout_in = h_dout | dout_out;
    assign wtbt_in = h_wtbt | wtbt_out;
    assign rply_in = m_rply | rply_out;
    // Undriven data lines toggle so that a stale value cannot pass.
    assign bus_da_in = h_oe ? h_da : (m_rply && din_out) ? mem_data : bus_da_oe ? bus_da_out : nz;
    initial
    begin
        iak_in = 0;
        dmg_in = 0;
        xfer_req = 0;
    end
    // grant only while requested, dropped at mastership
    always @(posedge clk_sys)
    begin
        nz <= ~nz;
        dmg_in <= dmr_out && !sack_out;
        cnt <= (sack_out && (din_out || dout_out)) ? cnt + 1 : 0;
        m_rply <= mem_en && sack_out && (din_out || dout_out) && cnt >= mem_lat;
    end
    // host times a slave transfer, releasing after the reply
    task sxfer(input logic w, input logic [15:0] d);
        @(posedge clk_sys);
        h_da <= d;
        h_oe <= 1;
        h_sync <= 1;
        h_wtbt <= w;
        xfer_req <= 1;
        @(posedge clk_sys);
        h_oe <= w;
        h_din <= !w;
        h_dout <= w;
        do @(posedge clk_sys); while (!rply_out);
        h_din <= 0;
        h_dout <= 0;
        do @(posedge clk_sys); while (rply_out);
        h_sync <= 0;
        h_wtbt <= 0;
        h_oe <= 0;
        xfer_req <= 0;
    endtask
    // acknowledge after the request, data-in raised first
    task iack();
        do @(posedge clk_sys); while (!irq_out);
        h_din <= 1;
        @(posedge clk_sys);
        iak_in <= 1;
        do @(posedge clk_sys); while (!rply_out);
        h_din <= 0;
        iak_in <= 0;
    endtask
endmodule // qbc_host
`default_nettype wire

/* File: dv/qbc_ctrl_tb.sv */
// Self-checking bench for the bus sequencer.
// Assumes qbc_ctrl, qbc_host and the bound checker.
`default_nettype none
module qbc_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic dma_req = 0, int_req = 0, wr_req = 0, cap_d = 0, rp_d = 0, mr_d = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic [15:0] per_rdata = 0, dma_addr = 0, dma_wdata = 0, bus_da_in, bus_da_out, per_wdata;
    logic [15:0] vec, d;
    logic pready, pslverr, sync_in, sync_out, sync_oe, din_in, din_out, din_oe, dout_in;
    logic dout_out, dout_oe, wtbt_in, wtbt_out, wtbt_oe, rply_in, rply_out, rply_oe, irq_out;
    logic dmr_out, sack_out, iak_in, dmg_in, bus_da_oe, xfer_req, per_capture, per_complete;
    logic per_error;
    logic [35:0] exp_q[$];
    int seed = 11, bad_count = 0, samples_checked = 0;
    qbc_ctrl u_dut (.*);
    qbc_host u_host (.*);
    initial forever #25 clk_sys = ~clk_sys;
    task check(input logic [35:0] seen, input logic [35:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task pop(input logic [35:0] seen);
        check(seen, (exp_q.size() > 0) ? exp_q.pop_front() : ~seen);
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1;
        do @(posedge clk_sys); while (!pready);
        psel <= 0;
        penable <= 0;
    endtask
    task results();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Each result seen takes the oldest expectation off the queue.
    always @(posedge clk_sys)
    begin
        if (pready && !pwrite) pop({4'h5, prdata});
        if (per_capture && !cap_d) pop({20'h10000, per_wdata});
        if (rply_out && bus_da_oe && !rp_d) pop({20'h40000, bus_da_out});
        if (rply_in && !mr_d && dout_out) pop({20'h60000, bus_da_out});
        if (per_complete) pop(36'h200000000);
        if (per_error) pop(36'h300000000);
        cap_d <= per_capture;
        rp_d <= rply_out && bus_da_oe;
        mr_d <= rply_in;
    end
    initial
    begin
        repeat (2) @(posedge clk_sys);
        rst <= 0;
        vec = $random(seed);
        exp_q.push_back(36'h500000001);
        exp_q.push_back({20'h50000, vec});
        exp_q.push_back(36'h500000000);
        apb(0, 8'h00, 0);
        apb(1, 8'h04, {16'h0, vec});
        apb(0, 8'h04, 0);
        apb(0, 8'h10, 0);
        $display("test apb done");
        for (int k = 0; k < 2; k++)
        begin
            d = $random(seed);
            per_rdata <= d;
            exp_q.push_back({k ? 20'h40000 : 20'h10000, d});
            u_host.sxfer(!k, d);
        end
        $display("test slave done");
        int_req <= 1;
        exp_q.push_back({20'h40000, vec});
        exp_q.push_back(36'h200000000);
        u_host.iack();
        do @(posedge clk_sys); while (!per_complete);
        int_req <= 0;
        $display("test interrupt done");
        for (int k = 0; k < 3; k++)
        begin
            d = $random(seed);
            u_host.mem_data <= d;
            u_host.mem_en <= (k != 2);
            u_host.mem_lat <= k * 4;
            wr_req <= (k == 1);
            dma_addr <= ~d;
            dma_wdata <= d;
            exp_q.push_back(k == 1 ? {20'h60000, d} : k == 0 ? {20'h10000, d} : 36'h300000000);
            if (k != 2) exp_q.push_back(36'h200000000);
            dma_req <= 1;
            do @(posedge clk_sys); while (!per_complete && !per_error);
            dma_req <= 0;
            repeat (4) @(posedge clk_sys);
            $display("test dma %0d done", k);
        end
        repeat (10) @(posedge clk_sys);
        check(36'(exp_q.size()), 36'h0);
        results();
    end
    initial
    begin
        repeat (4000) @(posedge clk_sys);
        bad_count++;
        results();
    end
endmodule // qbc_ctrl_tb
`default_nettype wire
